// File: hdl/twm_out_unit.sv
`timescale 1ns/1ps
`default_nettype none
module twm_out_unit
  import twm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       tick,
  input  wire logic [1:0] out_mode,
  input  wire twm_cls_e   cls,
  input  wire logic       toggle_ok,
  input  wire logic       match,
  input  wire logic       at_top_cmp,
  input  wire logic       at_bottom,
  input  wire logic       counting_up,
  input  wire logic       dir_out,
  input  wire logic       port_value,
  output logic            pin_o,
  output logic            pin_oe
);
  logic level_ff;
  logic nxt_level;
  logic connected;
  logic eff_match;

  // Disconnected unless the mode has a meaning here
  assign connected = (out_mode[1] | (out_mode[0] & toggle_ok)); // R2 R6 R9
  // Match at TOP ignored in fast PWM clear/set modes (not toggle), BOTTOM action still done
  assign eff_match = match & ~(cls == TWM_CLS_FAST & out_mode[1] & at_top_cmp); // R7

  always_comb begin
    nxt_level = level_ff;
    if (tick) begin
      case (cls)
        TWM_CLS_NONPWM: begin
          if (match) begin
            case (out_mode)
              OM_TOGGLE: nxt_level = ~level_ff; // R4
              OM_CLEAR:  nxt_level = 1'b0; // R4
              OM_SET:    nxt_level = 1'b1; // R4
              default:   nxt_level = level_ff;
            endcase
          end
        end
        TWM_CLS_FAST: begin
          if (out_mode == OM_TOGGLE && toggle_ok && match) begin
            nxt_level = ~level_ff; // R6
          end else if (out_mode[1] && eff_match) begin
            nxt_level = out_mode[0]; // R5
          end else if (out_mode[1] && at_bottom) begin
            nxt_level = ~out_mode[0]; // R5 R7
          end
        end
        TWM_CLS_DUAL: begin
          if (match) begin
            if (out_mode == OM_TOGGLE && toggle_ok) begin
              nxt_level = ~level_ff; // R9
            end else if (out_mode[1]) begin
              nxt_level = out_mode[0] ^ ~counting_up; // R8
            end
          end
        end
        default: nxt_level = level_ff;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level; // R1
    end
  end

  assign pin_o  = connected ? level_ff : port_value; // R2
  assign pin_oe = dir_out; // R3
endmodule
`default_nettype wire

// File: hdl/twm_timer.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: Synchronous design; tick only enables counting
// R2: Nonzero output mode takes over pin; here toggle mode 01 leaves the pin to the port where toggle is not allowed
// R3: Pin driver follows direction bit only
// R4: Non-PWM: off, toggle, clear, set
// R5: Fast PWM: 10 non-inverting, 11 inverting
// R6: Fast PWM toggle A only modes 14,15
// R7: Fast PWM compare at TOP ignored
// R8: Dual-slope: clear up, set down
// R9: Dual-slope toggle A only modes 9,11
// R10: Mode bits split over two registers
// R11: Normal and CLEAR_ON_MATCH_MODE TOP, immediate update
// R12: Phase correct TOP, update TOP, flag BOTTOM
// R13: Fast PWM update BOTTOM, flag TOP
// R14: Freq correct update BOTTOM, flag BOTTOM
// R15: BOTTOM timing mirrors TOP timing
// R16: Legacy bit positions kept compatible
// R17: Mode 8 reverses at capture value
// R18: Mode 7 TOP 0x03FF, mode 14 capture
// R19: Mode 13 reserved, never selected
module twm_timer
  import twm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       timer_tick,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic [1:0] port_value,
  output logic            compare_out_a,
  output logic            compare_out_a_oe,
  output logic            compare_out_b,
  output logic            compare_out_b_oe,
  output logic            irq
);
  // ==========================================================
  // Registers
  logic [7:0]  ctrl_a_ff;
  logic [7:0]  ctrl_b_ff;
  logic [15:0] cmp_a_buf_ff;
  logic [15:0] cmp_b_buf_ff;
  logic [15:0] cmp_a_ff;
  logic [15:0] cmp_b_ff;
  logic [15:0] cap_ff;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        down_ff;
  logic        nxt_down;
  logic [2:0]  stat_ff;
  logic [2:0]  nxt_stat;
  logic [2:0]  mask_ff;
  logic [1:0]  dir_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;

  function automatic logic [15:0] set_lo(input logic [15:0] v, input logic [7:0] b);
    set_lo = {v[15:8], b};
  endfunction
  function automatic logic [15:0] set_hi(input logic [15:0] v, input logic [7:0] b);
    set_hi = {b, v[7:0]};
  endfunction

  // ==========================================================
  // Mode decode
  logic [3:0]  waveform_mode;
  twm_cls_e    cls;
  twm_topsrc_e top_src;
  logic [15:0] fixed_top;
  logic [15:0] top_val;
  logic        upd_imm;
  logic        upd_at_top;
  logic        is_pfc;

  // Low pair in control A, high pair in control B; same positions as legacy bits
  assign waveform_mode = {ctrl_b_ff[CB_WGM_HI:CB_WGM_LO], ctrl_a_ff[1:0]}; // R10 R16

  always_comb begin
    cls       = TWM_CLS_NONPWM;
    top_src   = TWM_TOP_FIXED;
    fixed_top = TOP_MAX;
    case (waveform_mode)
      WM_NORMAL:  fixed_top = TOP_MAX; // R11
      WM_CTC_CMP: top_src = TWM_TOP_CMP; // R11
      WM_CTC_CAP: top_src = TWM_TOP_CAP; // R11
      WM_PC8: begin
        cls       = TWM_CLS_DUAL;
        fixed_top = TOP_8BIT; // R12
      end
      WM_PC9: begin
        cls       = TWM_CLS_DUAL;
        fixed_top = TOP_9BIT; // R12
      end
      WM_PC10: begin
        cls       = TWM_CLS_DUAL;
        fixed_top = TOP_10BIT; // R12
      end
      WM_PC_CAP, WM_PFC_CAP: begin
        cls     = TWM_CLS_DUAL;
        top_src = TWM_TOP_CAP; // R12 R17
      end
      WM_PC_CMP, WM_PFC_CMP: begin
        cls     = TWM_CLS_DUAL;
        top_src = TWM_TOP_CMP; // R12 R14
      end
      WM_FP8: begin
        cls       = TWM_CLS_FAST;
        fixed_top = TOP_8BIT; // R13
      end
      WM_FP9: begin
        cls       = TWM_CLS_FAST;
        fixed_top = TOP_9BIT; // R13
      end
      WM_FP10: begin
        cls       = TWM_CLS_FAST;
        fixed_top = TOP_10BIT; // R18
      end
      WM_FP_CAP: begin
        cls     = TWM_CLS_FAST;
        top_src = TWM_TOP_CAP; // R18
      end
      WM_FP_CMP: begin
        cls     = TWM_CLS_FAST;
        top_src = TWM_TOP_CMP; // R13
      end
      // Reserved mode 13 falls back to normal counting
      default: cls = TWM_CLS_NONPWM; // R19
    endcase
  end

  assign top_val    = (top_src == TWM_TOP_CMP) ? cmp_a_ff :
                      (top_src == TWM_TOP_CAP) ? cap_ff : fixed_top;
  assign is_pfc     = (waveform_mode == WM_PFC_CAP) | (waveform_mode == WM_PFC_CMP);
  assign upd_imm    = (cls == TWM_CLS_NONPWM); // R11
  assign upd_at_top = (cls == TWM_CLS_DUAL) & ~is_pfc; // R12

  // ==========================================================
  // Counter
  logic at_top;
  logic at_bottom;
  logic at_max;
  logic cnt_wr;
  logic upd_evt;
  logic ovf_evt;
  logic match_a;
  logic match_b;
  logic toggle_ok;

  assign at_top    = (cnt_ff == top_val);
  assign at_bottom = (cnt_ff == BOTTOM);
  assign at_max    = (cnt_ff == TOP_MAX);
  assign cnt_wr    = wr_stb & ((addr == ADDR_CNT_LO) | (addr == ADDR_CNT_HI));

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_down = down_ff;
    if (cls == TWM_CLS_DUAL) begin
      // Direction turns at TOP and BOTTOM; value steps down from TOP on the next tick
      if (at_top) begin
        nxt_down = 1'b1; // R17
      end else if (at_bottom) begin
        nxt_down = 1'b0;
      end
      nxt_cnt = (at_top | (down_ff & ~at_bottom)) ? cnt_ff - ONE : cnt_ff + ONE;
    end else begin
      nxt_down = 1'b0;
      nxt_cnt  = at_top ? BOTTOM : cnt_ff + ONE;
    end
  end

  // Flag points: MAX in non-PWM, TOP in fast PWM, BOTTOM in dual-slope
  assign ovf_evt = timer_tick & ((cls == TWM_CLS_NONPWM) ? at_max :
                                 (cls == TWM_CLS_FAST)   ? at_top : at_bottom); // R11 R12 R13 R14 R15
  assign upd_evt = timer_tick & (upd_at_top ? at_top : at_bottom); // R13 R14 R15
  assign match_a = timer_tick & (cnt_ff == cmp_a_ff);
  assign match_b = timer_tick & (cnt_ff == cmp_b_ff);
  // Toggle always allowed in non-PWM; fast PWM only in modes 14 and 15, dual-slope only in A-as-TOP modes 9 and 11
  assign toggle_ok = (cls == TWM_CLS_FAST) ? ((waveform_mode == WM_FP_CAP) | (waveform_mode == WM_FP_CMP)) :
                     (cls == TWM_CLS_DUAL) ? ((waveform_mode == WM_PFC_CMP) | (waveform_mode == WM_PC_CMP)) :
                     1'b1; // R4 R6 R9

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff  <= RST_WORD;
      down_ff <= 1'b0;
    end else if (cnt_wr) begin
      cnt_ff <= (addr == ADDR_CNT_LO) ? set_lo(cnt_ff, wdata) : set_hi(cnt_ff, wdata);
    end else if (timer_tick) begin
      cnt_ff  <= nxt_cnt; // R1
      down_ff <= nxt_down;
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_a_ff <= RST_BYTE;
      ctrl_b_ff <= RST_BYTE;
      cap_ff    <= RST_WORD;
      mask_ff   <= 3'h0;
      dir_ff    <= 2'h0;
    end else if (wr_stb) begin
      case (addr)
        ADDR_CTRL_A:   ctrl_a_ff <= wdata & CA_WMASK;
        ADDR_CTRL_B:   ctrl_b_ff <= wdata & CB_WMASK;
        ADDR_CAP_LO:   cap_ff    <= set_lo(cap_ff, wdata);
        ADDR_CAP_HI:   cap_ff    <= set_hi(cap_ff, wdata);
        ADDR_IRQ_MASK: mask_ff   <= wdata[2:0];
        ADDR_PIN_DIR:  dir_ff    <= wdata[1:0];
        default:       ctrl_a_ff <= ctrl_a_ff;
      endcase
    end
  end

  // Compare buffers and active values
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_a_buf_ff <= RST_WORD;
      cmp_b_buf_ff <= RST_WORD;
    end else if (wr_stb) begin
      case (addr)
        ADDR_CMP_A_LO: cmp_a_buf_ff <= set_lo(cmp_a_buf_ff, wdata);
        ADDR_CMP_A_HI: cmp_a_buf_ff <= set_hi(cmp_a_buf_ff, wdata);
        ADDR_CMP_B_LO: cmp_b_buf_ff <= set_lo(cmp_b_buf_ff, wdata);
        ADDR_CMP_B_HI: cmp_b_buf_ff <= set_hi(cmp_b_buf_ff, wdata);
        default:       cmp_a_buf_ff <= cmp_a_buf_ff;
      endcase
    end
  end

  // Buffered copy only moves at the mode's update point
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_a_ff <= RST_WORD;
      cmp_b_ff <= RST_WORD;
    end else if (upd_imm | upd_evt) begin
      cmp_a_ff <= cmp_a_buf_ff; // R11 R13 R14
      cmp_b_ff <= cmp_b_buf_ff;
    end
  end

  // ==========================================================
  // Interrupt status; set wins over write-one-to-clear
  logic [2:0] evt;
  logic [2:0] clr;
  assign evt = {match_b, match_a, ovf_evt};
  assign clr = (wr_stb & (addr == ADDR_IRQ_STAT)) ? (wdata[2:0] & IRQ_WMASK) : 3'h0;
  assign nxt_stat = (stat_ff & ~clr) | evt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_ff <= 3'h0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end
  assign irq = |(stat_ff & mask_ff);

  // ==========================================================
  // Read path
  always_comb begin
    case (addr)
      ADDR_CTRL_A:   nxt_rdata = ctrl_a_ff;
      ADDR_CTRL_B:   nxt_rdata = ctrl_b_ff;
      ADDR_CNT_LO:   nxt_rdata = cnt_ff[7:0];
      ADDR_CNT_HI:   nxt_rdata = cnt_ff[15:8];
      ADDR_CMP_A_LO: nxt_rdata = cmp_a_buf_ff[7:0];
      ADDR_CMP_A_HI: nxt_rdata = cmp_a_buf_ff[15:8];
      ADDR_CMP_B_LO: nxt_rdata = cmp_b_buf_ff[7:0];
      ADDR_CMP_B_HI: nxt_rdata = cmp_b_buf_ff[15:8];
      ADDR_CAP_LO:   nxt_rdata = cap_ff[7:0];
      ADDR_CAP_HI:   nxt_rdata = cap_ff[15:8];
      ADDR_IRQ_STAT: nxt_rdata = {5'h00, stat_ff};
      ADDR_IRQ_MASK: nxt_rdata = {5'h00, mask_ff};
      ADDR_PIN_DIR:  nxt_rdata = {6'h00, dir_ff};
      default:       nxt_rdata = RST_BYTE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= RST_BYTE;
    end else begin
      rdata_ff <= rd_stb ? nxt_rdata : RST_BYTE;
    end
  end
  assign rdata = rdata_ff;

  // ==========================================================
  // Output units
  twm_out_unit u_out_a (
    .clk         (clk),
    .arst_n      (arst_n),
    .tick        (timer_tick),
    .out_mode    (ctrl_a_ff[CA_MODE_A_HI:CA_MODE_A_LO]),
    .cls         (cls),
    .toggle_ok   (toggle_ok),
    .match       (match_a),
    .at_top_cmp  (cmp_a_ff == top_val),
    .at_bottom   (at_bottom),
    .counting_up (~down_ff),
    .dir_out     (dir_ff[0]),
    .port_value  (port_value[0]),
    .pin_o       (compare_out_a),
    .pin_oe      (compare_out_a_oe)
  );

  // Channel B never toggles in PWM classes
  twm_out_unit u_out_b (
    .clk         (clk),
    .arst_n      (arst_n),
    .tick        (timer_tick),
    .out_mode    (ctrl_a_ff[CA_MODE_B_HI:CA_MODE_B_LO]),
    .cls         (cls),
    .toggle_ok   (cls == TWM_CLS_NONPWM),
    .match       (match_b),
    .at_top_cmp  (cmp_b_ff == top_val),
    .at_bottom   (at_bottom),
    .counting_up (~down_ff),
    .dir_out     (dir_ff[1]),
    .port_value  (port_value[1]),
    .pin_o       (compare_out_b),
    .pin_oe      (compare_out_b_oe)
  );

  // ==========================================================
  // Checks
  property p_oe_dir;
    @(posedge clk) disable iff (!arst_n) compare_out_a_oe == dir_ff[0];
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("oe not following direction"); // R3

  property p_hold_no_tick;
    @(posedge clk) disable iff (!arst_n) (!timer_tick && !cnt_wr) |=> $stable(cnt_ff);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick) else $error("counter moved without tick"); // R1

  property p_ovf_normal;
    @(posedge clk) disable iff (!arst_n) (timer_tick && waveform_mode == WM_NORMAL && at_max) |=> stat_ff[IRQ_OVF];
  endproperty
  a_ovf_normal: assert property (p_ovf_normal) else $error("overflow not flagged at max"); // R11

  property p_fast_wrap;
    @(posedge clk) disable iff (!arst_n)
      (timer_tick && !cnt_wr && cls == TWM_CLS_FAST && at_top) |=> (cnt_ff == BOTTOM) && stat_ff[IRQ_OVF];
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast pwm wrap or flag wrong"); // R13

  property p_dual_turn;
    @(posedge clk) disable iff (!arst_n)
      (timer_tick && !cnt_wr && cls == TWM_CLS_DUAL && at_top && !at_bottom) |=> down_ff;
  endproperty
  a_dual_turn: assert property (p_dual_turn) else $error("dual slope did not turn at top"); // R17

  property p_upd_top;
    @(posedge clk) disable iff (!arst_n)
      (upd_at_top && timer_tick && !at_top && !at_bottom && !upd_imm) |=> $stable(cmp_a_ff);
  endproperty
  a_upd_top: assert property (p_upd_top) else $error("compare updated off its point"); // R12

  property p_pin_mux;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_a_ff[CA_MODE_A_HI:CA_MODE_A_LO] == OM_OFF) |-> compare_out_a == port_value[0];
  endproperty
  a_pin_mux: assert property (p_pin_mux) else $error("pin not returned to port"); // R2

  property p_nonpwm_set;
    @(posedge clk) disable iff (!arst_n)
      (cls == TWM_CLS_NONPWM && match_a && ctrl_a_ff[CA_MODE_A_HI:CA_MODE_A_LO] == OM_SET) |=> compare_out_a;
  endproperty
  a_nonpwm_set: assert property (p_nonpwm_set) else $error("set on match failed"); // R4
endmodule
`default_nettype wire

// File: shared/twm_pkg.sv
`default_nettype none
package twm_pkg;
  // Register map
  localparam logic [7:0]  ADDR_CTRL_A   = 8'h80;
  localparam logic [7:0]  ADDR_CTRL_B   = 8'h81;
  localparam logic [7:0]  ADDR_CMP_A_LO = 8'h88;
  localparam logic [7:0]  ADDR_CMP_A_HI = 8'h89;
  localparam logic [7:0]  ADDR_CMP_B_LO = 8'h8a;
  localparam logic [7:0]  ADDR_CMP_B_HI = 8'h8b;
  localparam logic [7:0]  ADDR_CAP_LO   = 8'h86;
  localparam logic [7:0]  ADDR_CAP_HI   = 8'h87;
  localparam logic [7:0]  ADDR_CNT_LO   = 8'h84;
  localparam logic [7:0]  ADDR_CNT_HI   = 8'h85;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h90;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h91;
  localparam logic [7:0]  ADDR_PIN_DIR  = 8'h92;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_WORD      = 16'h0000;
  // Control A and B fields
  localparam int          CA_MODE_A_HI  = 7;
  localparam int          CA_MODE_A_LO  = 6;
  localparam int          CA_MODE_B_HI  = 5;
  localparam int          CA_MODE_B_LO  = 4;
  localparam logic [7:0]  CA_WMASK      = 8'hf3;
  localparam logic [7:0]  CB_WMASK      = 8'h18;
  localparam int          CB_WGM_HI     = 4;
  localparam int          CB_WGM_LO     = 3;
  // Interrupt status bits
  localparam int          IRQ_OVF       = 0;
  localparam int          IRQ_CMP_A     = 1;
  localparam int          IRQ_CMP_B     = 2;
  localparam logic [2:0]  IRQ_WMASK     = 3'h7;
  // Fixed TOP values
  localparam logic [15:0] TOP_MAX       = 16'hffff;
  localparam logic [15:0] TOP_8BIT      = 16'h00ff;
  localparam logic [15:0] TOP_9BIT      = 16'h01ff;
  localparam logic [15:0] TOP_10BIT     = 16'h03ff;
  localparam logic [15:0] BOTTOM        = 16'h0000;
  localparam logic [15:0] ONE           = 16'h0001;
  // Waveform modes
  localparam logic [3:0]  WM_NORMAL     = 4'h0;
  localparam logic [3:0]  WM_PC8        = 4'h1;
  localparam logic [3:0]  WM_PC9        = 4'h2;
  localparam logic [3:0]  WM_PC10       = 4'h3;
  localparam logic [3:0]  WM_CTC_CMP    = 4'h4;
  localparam logic [3:0]  WM_FP8        = 4'h5;
  localparam logic [3:0]  WM_FP9        = 4'h6;
  localparam logic [3:0]  WM_FP10       = 4'h7;
  localparam logic [3:0]  WM_PFC_CAP    = 4'h8;
  localparam logic [3:0]  WM_PFC_CMP    = 4'h9;
  localparam logic [3:0]  WM_PC_CAP     = 4'ha;
  localparam logic [3:0]  WM_PC_CMP     = 4'hb;
  localparam logic [3:0]  WM_CTC_CAP    = 4'hc;
  localparam logic [3:0]  WM_FP_CAP     = 4'he;
  localparam logic [3:0]  WM_FP_CMP     = 4'hf;
  // Compare output modes
  localparam logic [1:0]  OM_OFF        = 2'h0;
  localparam logic [1:0]  OM_TOGGLE     = 2'h1;
  localparam logic [1:0]  OM_CLEAR      = 2'h2;
  localparam logic [1:0]  OM_SET        = 2'h3;
  typedef enum logic [1:0] {
    TWM_CLS_NONPWM = 2'b00,
    TWM_CLS_FAST   = 2'b01,
    TWM_CLS_DUAL   = 2'b11
  } twm_cls_e;
  typedef enum logic [1:0] {
    TWM_TOP_FIXED = 2'h0,
    TWM_TOP_CMP   = 2'h1,
    TWM_TOP_CAP   = 2'h2
  } twm_topsrc_e;
endpackage
`default_nettype wire

// File: verification/timer16_waveform_mode_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_waveform_mode_control_tb;
  import twm_pkg::*;
  typedef struct packed {
    logic [3:0]  m;
    logic [15:0] top;
    logic        d;
    logic        ov;
  } twm_row_s;
  typedef struct packed {
    logic [7:0] ca;
    logic [7:0] cb;
    logic [1:0] disc;
  } twm_disc_s;
  localparam logic [15:0] CMP_TOP = 16'h0040;
  localparam logic [15:0] CAP_TOP = 16'h0050;
  // Reserved mode 13 is never selected, so it has no row
  localparam twm_row_s ROWS [15] = '{
    '{WM_NORMAL, TOP_MAX, 1'b0, 1'b1}, '{WM_PC8, TOP_8BIT, 1'b1, 1'b0}, '{WM_PC9, TOP_9BIT, 1'b1, 1'b0},
    '{WM_PC10, TOP_10BIT, 1'b1, 1'b0}, '{WM_CTC_CMP, CMP_TOP, 1'b0, 1'b0}, '{WM_FP8, TOP_8BIT, 1'b0, 1'b1},
    '{WM_FP9, TOP_9BIT, 1'b0, 1'b1}, '{WM_FP10, TOP_10BIT, 1'b0, 1'b1}, '{WM_PFC_CAP, CAP_TOP, 1'b1, 1'b0},
    '{WM_PFC_CMP, CMP_TOP, 1'b1, 1'b0}, '{WM_PC_CAP, CAP_TOP, 1'b1, 1'b0}, '{WM_PC_CMP, CMP_TOP, 1'b1, 1'b0},
    '{WM_CTC_CAP, CAP_TOP, 1'b0, 1'b0}, '{WM_FP_CAP, CAP_TOP, 1'b0, 1'b1}, '{WM_FP_CMP, CMP_TOP, 1'b0, 1'b1}};
  localparam twm_disc_s DISC [7] = '{
    '{8'h50, 8'h08, 2'b00}, '{8'h52, 8'h18, 2'b10}, '{8'h51, 8'h08, 2'b11}, '{8'h53, 8'h10, 2'b10},
    '{8'h51, 8'h10, 2'b10}, '{8'h52, 8'h10, 2'b11}, '{8'h00, 8'h00, 2'b11}};
  logic       clk        = 1'b0;
  logic       arst_n     = 1'b0;
  logic       timer_tick = 1'b0;
  logic [7:0] addr       = 8'h00;
  logic [7:0] wdata      = 8'h00;
  logic       wr_stb     = 1'b0;
  logic       rd_stb     = 1'b0;
  logic [1:0] port_value = 2'h0;
  logic [7:0] rdata;
  logic       ca;
  logic       ca_oe;
  logic       cb;
  logic       cb_oe;
  logic       irq;
  logic       lvl_a;
  logic       lvl_b;
  logic       watch      = 1'b0;
  logic       low_seen   = 1'b0;
  int         error_cnt  = 0;
  int         tests_run  = 0;
  int         cycles     = 0;

  // ==========
  // Design and pads
  twm_timer uut (.clk(clk), .arst_n(arst_n), .timer_tick(timer_tick), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .port_value(port_value), .compare_out_a(ca),
    .compare_out_a_oe(ca_oe), .compare_out_b(cb), .compare_out_b_oe(cb_oe), .irq(irq));
  twm_pin_model pad_a (.pin_o(ca), .pin_oe(ca_oe), .pin_level(lvl_a));
  twm_pin_model pad_b (.pin_o(cb), .pin_oe(cb_oe), .pin_level(lvl_b));

  always #50 clk = ~clk;

  // Sampled mid-cycle so pin updates have settled
  always @(negedge clk) begin
    if (watch && ca !== 1'b1) begin
      low_seen = 1'b1;
    end
  end

  // ==========
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("wrong value at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  // ==========
  // Tasks
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: level got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 8'h01, v[15:8]);
  endtask

  // Gap cycle between ticks so a design that counts every clock is caught
  task automatic ticks(input int n);
    repeat (n) begin
      timer_tick <= 1'b1;
      @(posedge clk);
      timer_tick <= 1'b0;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic pins(input logic a, input logic b);
    chk_pin(ca, a);
    chk_pin(cb, b);
  endtask

  // ==========
  // Main sequence
  initial begin
    logic [7:0]  b;
    logic [15:0] w;
    do_reset();
    rd(ADDR_CTRL_A, b);
    chk_val({8'h00, b}, {8'h00, RST_BYTE});
    wr(ADDR_CTRL_A, 8'hff);
    rd(ADDR_CTRL_A, b);
    chk_val({8'h00, b}, {8'h00, CA_WMASK});
    wr(ADDR_CTRL_B, 8'hff);
    rd(ADDR_CTRL_B, b);
    chk_val({8'h00, b}, {8'h00, CB_WMASK});
    wr(8'h8f, 8'hff);
    rd(8'h8f, b);
    chk_val({8'h00, b}, 16'h0000);
    $display("end of test: registers");
    for (int i = 0; i < 15; i++) begin
      do_reset();
      wr16(ADDR_CMP_A_LO, CMP_TOP);
      wr16(ADDR_CAP_LO, CAP_TOP);
      wr(ADDR_CTRL_A, {6'h00, ROWS[i].m[1:0]});
      wr(ADDR_CTRL_B, {3'h0, ROWS[i].m[3:2], 3'h0});
      wr16(ADDR_CNT_LO, ROWS[i].top - 16'h0003);
      ticks(5);
      rd16(ADDR_CNT_LO, w);
      chk_val(w, ROWS[i].d ? ROWS[i].top - 16'h0002 : ONE);
      rd(ADDR_IRQ_STAT, b);
      chk_pin(b[IRQ_OVF], ROWS[i].ov);
    end
    $display("end of test: mode table");
    do_reset();
    wr(ADDR_PIN_DIR, 8'h03);
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_CTRL_A, DISC[i].ca);
      wr(ADDR_CTRL_B, DISC[i].cb);
      for (int v = 0; v < 4; v += 3) begin
        port_value <= v[1:0];
        repeat (2) @(posedge clk);
        #1;
        pins(DISC[i].disc[0] & v[0], DISC[i].disc[1] & v[1]);
        chk_pin(ca_oe & cb_oe, 1'b1);
      end
    end
    $display("end of test: pin takeover");
    do_reset();
    wr16(ADDR_CMP_A_LO, 16'h0005);
    wr16(ADDR_CMP_B_LO, 16'h0002);
    wr(ADDR_PIN_DIR, 8'h01);
    wr(ADDR_CTRL_B, 8'h08);
    wr(ADDR_CTRL_A, 8'he0);
    ticks(7);
    pins(1'b1, 1'b0);
    chk_pin(ca_oe, 1'b1);
    chk_pin(cb_oe, 1'b0);
    chk_pin(lvl_b, 1'b1);
    chk_pin(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h02);
    #1;
    chk_pin(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 8'h02);
    #1;
    chk_pin(irq, 1'b0);
    rd(ADDR_IRQ_STAT, b);
    chk_val({8'h00, b}, 16'h0004);
    wr(ADDR_CTRL_A, 8'h50);
    ticks(6);
    pins(1'b0, 1'b1);
    chk_pin(lvl_a, 1'b0);
    $display("end of test: non-pwm outputs");
    do_reset();
    wr16(ADDR_CAP_LO, 16'h0010);
    wr16(ADDR_CMP_A_LO, 16'h0008);
    wr16(ADDR_CMP_B_LO, 16'h0004);
    wr(ADDR_PIN_DIR, 8'h03);
    wr(ADDR_CTRL_B, 8'h18);
    wr(ADDR_CTRL_A, 8'hb2);
    ticks(20);
    pins(1'b1, 1'b0);
    ticks(6);
    pins(1'b0, 1'b1);
    wr16(ADDR_CMP_A_LO, 16'h0010);
    ticks(20);
    watch = 1'b1;
    ticks(18);
    watch = 1'b0;
    chk_pin(low_seen, 1'b0);
    $display("end of test: fast pwm");
    do_reset();
    wr16(ADDR_CAP_LO, 16'h0010);
    wr16(ADDR_CMP_B_LO, 16'h0004);
    wr(ADDR_CTRL_B, 8'h10);
    wr(ADDR_CTRL_A, 8'h32);
    ticks(6);
    chk_pin(cb, 1'b1);
    ticks(24);
    chk_pin(cb, 1'b0);
    wr(ADDR_CTRL_A, 8'h22);
    ticks(32);
    chk_pin(cb, 1'b1);
    $display("end of test: dual slope");
    wrap_up();
  end
endmodule
`default_nettype wire

// File: verification/twm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Pad with an external pull-up
module twm_pin_model (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      pin_level
);
  // Undriven pad floats up, never echoes the last driven level
  assign pin_level = pin_oe ? pin_o : 1'b1;
endmodule
`default_nettype wire
